// [pkg/dual_rx_config_params.svh]
// register offsets, reset values and field positions of the dual configuration bank
`ifndef DUAL_RX_CONFIG_PARAMS_SVH
`define DUAL_RX_CONFIG_PARAMS_SVH
// register indices (byte address is four times the index)
`define IDX_A_ON_LOW 7'h1F
`define IDX_A_ON_HIGH 7'h20
`define IDX_A_MOD 7'h21
`define IDX_A_PLL1 7'h22
`define IDX_A_PLL2 7'h23
`define IDX_A_PLL3 7'h24
`define IDX_A_WAKE 7'h25
`define IDX_A_PAT_LOW 7'h26
`define IDX_A_PAT_HIGH 7'h27
`define IDX_A_CHIP_CNT 7'h28
`define IDX_B_ON_LOW 7'h40
`define IDX_B_ON_HIGH 7'h41
`define IDX_B_MOD 7'h42
`define IDX_B_PLL1 7'h43
`define IDX_B_PLL2 7'h44
`define IDX_B_PLL3 7'h45
`define IDX_B_WAKE 7'h46
`define IDX_B_PAT_LOW 7'h47
`define IDX_B_PAT_HIGH 7'h48
`define IDX_B_CHIP_CNT 7'h49
// distance between the two sets
`define SET_B_DISTANCE 7'h21
// own mode select register
`define IDX_MODE_SEL 7'h70
// reset values
`define RST_ON_LOW 8'h01
`define RST_ON_HIGH 8'h00
`define RST_MOD 8'h04
`define RST_PLL1 8'h29
`define RST_PLL2 8'h08
`define RST_PLL3 8'h0A
`define RST_WAKE 8'h00
`define RST_PAT 8'h00
`define RST_CHIP_CNT 8'h00
// field positions
`define ON_HIGH_MSB 5
`define MOD_CHAN_MSB 3
`define MOD_CHAN_LSB 2
`define MOD_TYPE_MSB 1
`define BAND_MSB 6
`define BAND_LSB 5
`define DIV_R_MSB 4
`define DIV_R_LSB 2
`define DIV_S_MSB 1
`define WAKE_MSB 1
`define CHIP_CNT_MSB 6
`endif

// [pkg/dual_rx_config_pkg.sv]
// types of the dual configuration bank
package dual_rx_config_pkg;
   typedef enum logic [1:0] {MODE_SLAVE, MODE_POLL, MODE_POLL_RUN} op_mode_t;
   typedef enum logic {MOD_ASK, MOD_FSK} mod_kind_t;
   typedef enum logic [1:0] {WAKE_PATTERN, WAKE_RANDOM, WAKE_EQUAL, WAKE_SYNC} wake_crit_t;
   // one configuration set as stored
   typedef struct packed {
      logic [7:0] onLow;
      logic [7:0] onHigh;
      logic [7:0] mod;
      logic [7:0] pll1;
      logic [7:0] pll2;
      logic [7:0] pll3;
      logic [7:0] wake;
      logic [7:0] patLow;
      logic [7:0] patHigh;
      logic [7:0] chipCnt;
   } conf_set_t;
   // decoded divider of one channel
   typedef struct packed {
      logic [3:0] divR;
      logic signed [1:0] divS;
   } chan_div_t;
   // decoded settings handed to the receiver core
   typedef struct packed {
      logic [14:0] onTimePeriods;
      mod_kind_t modKind;
      logic [1:0] chanCount;
      logic [1:0] bandSelect;
      logic [1:0] prescalerA;
      chan_div_t chanDiv;
      wake_crit_t wakeCriterion;
      logic [6:0] wakeChipCount;
      logic [15:0] wakePattern;
   } rx_setting_t;
endpackage

// [hdl/dual_rx_config_bank.sv]
// dual configuration register bank with AXI4-Lite slave and decoded outputs
// Operation
// - on-time is period times 14-bit setting
// - two-bit field picks ASK/FSK per mode
// - channel count field, slave uses channel one
// - band field picks band and prescaler A
// - divider R code zero means eight
// - divider S decodes +1,0,-1,0
// - channel one both modes, two/three polling
// - wake criterion selects detection mode
// - sync wake ignores chip count setting
// - low pattern byte holds bits 7..0
// - on-time low byte resets to one
// - high pattern byte follows low byte
// - seven-bit chip count limits detection
`include "dual_rx_config_params.svh"

// write: address and data in either order, answered two edges after both
// read: answered one edge after the address; bank registers read as zero
// only byte lane 0 carries data; protection bits are ignored
module dual_rx_config_bank
   import dual_rx_config_pkg::*;
#(
   parameter int ADDR_W = 9
) (
   input wire logic clk,
   input wire logic rst_n,
   // write address channel
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // write data channel
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // write response channel
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // read address channel
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // read data channel
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // decoded settings of the active set
   output rx_setting_t setting,
   // current operating mode and active set, read back over the bus
   output logic [1:0] activeMode,
   output logic activeSetB
);
   // response codes of the write and read channels
   localparam logic [1:0] RESP_OKAY = 2'h0; // access decoded
   localparam logic [1:0] RESP_SLVERR = 2'h2; // unmapped index

   // stored sets and own mode register
   conf_set_t setA; // configuration set A
   conf_set_t setB; // configuration set B
   logic [2:0] modeSel; // own register: mode in 1:0, set in 2

   // write path state
   logic awHeld; // write address latched
   logic wHeld; // write data latched
   logic [6:0] awIdx; // latched word index
   logic [31:0] wData; // latched write data
   logic wLane0; // latched strobe of byte lane 0
   logic [6:0] next_idx; // word index from latched address
   logic doWrite; // both halves present and no response pending
   logic hitA; // index falls in set A
   logic hitB; // index falls in set B
   logic hitMode; // index is the mode register

   // address and data may arrive in either order
   // a pending response blocks both halves
   assign s_axi_awready = !awHeld && !s_axi_bvalid;
   assign s_axi_wready = !wHeld && !s_axi_bvalid;
   assign doWrite = awHeld && wHeld && !s_axi_bvalid;
   // index of the pending write
   assign next_idx = awIdx;

   // own mode register decode; set hits come from the set stores
   assign hitMode = (next_idx == `IDX_MODE_SEL);

   // latch write address
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         // nothing held after reset
         awHeld <= 1'b0;
         awIdx <= 7'h00;
      end else if (s_axi_awvalid && s_axi_awready) begin
         // keep the word index, byte offset dropped
         awHeld <= 1'b1;
         awIdx <= s_axi_awaddr[8:2];
      end else if (doWrite) begin
         // released once the write is applied
         awHeld <= 1'b0;
      end
   end

   // latch write data
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         // no data held after reset
         wHeld <= 1'b0;
         wData <= 32'h0000_0000;
         wLane0 <= 1'b0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         // keep data and the lane 0 strobe
         wHeld <= 1'b1;
         wData <= s_axi_wdata;
         wLane0 <= s_axi_wstrb[0];
      end else if (doWrite) begin
         // released once the write is applied
         wHeld <= 1'b0;
      end
   end

   // write response, error for unmapped index
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         // no answer pending after reset
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else if (doWrite) begin
         // answer the applied write
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= (hitA || hitB || hitMode) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         // answer taken by the master
         s_axi_bvalid <= 1'b0;
      end
   end

   // set A storage, touched only by set A indices
   conf_set_store #(
      .FIRST_IDX(`IDX_A_ON_LOW)
   ) u_set_a (
      .clk(clk),
      .rst_n(rst_n),
      .wrEn(doWrite),
      .wrIdx(next_idx),
      .wrByte(wData[7:0]),
      .wrLane(wLane0),
      .hit(hitA),
      .regs(setA)
   );

   // set B storage, same layout placed a fixed distance above set A
   conf_set_store #(
      .FIRST_IDX(`IDX_A_ON_LOW + `SET_B_DISTANCE)
   ) u_set_b (
      .clk(clk),
      .rst_n(rst_n),
      .wrEn(doWrite),
      .wrIdx(next_idx),
      .wrByte(wData[7:0]),
      .wrLane(wLane0),
      .hit(hitB),
      .regs(setB)
   );

   // mode and set selector
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         // slave mode on set A after reset
         modeSel <= 3'h0;
      end else if (doWrite && hitMode && wLane0) begin
         // mode in bits 1:0, set in bit 2
         modeSel <= wData[2:0];
      end
   end

   // read channel: bank reads zero, mode register reads back
   // one read at a time: no new address while data waits
   assign s_axi_arready = !s_axi_rvalid;
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         // no data pending after reset
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         // answer on the next edge
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= RESP_OKAY;
         if (s_axi_araddr[8:2] == `IDX_MODE_SEL) begin
            s_axi_rdata <= {29'h0000_0000, activeSetB, activeMode};
         end else begin
            s_axi_rdata <= 32'h0000_0000;
         end
      end else if (s_axi_rready) begin
         // data taken by the master
         s_axi_rvalid <= 1'b0;
      end
   end

   // decode of the active set
   conf_set_t cur; // selected set
   logic [1:0] chanPick; // channel in use
   logic [7:0] pllReg; // pll register of that channel
   op_mode_t mode; // decoded operating mode
   always_comb begin
      // set chosen by bit 2 of the mode register
      cur = modeSel[2] ? setB : setA;
      unique case (modeSel[1:0])
         2'h1: mode = MODE_POLL;
         2'h2: mode = MODE_POLL_RUN;
         // code 3 falls back to slave
         default: mode = MODE_SLAVE;
      endcase
      // slave mode always runs channel one
      if (mode == MODE_SLAVE) begin
         chanPick = 2'h0;
      end else begin
         chanPick = cur.mod[`MOD_CHAN_MSB:`MOD_CHAN_LSB];
      end
      unique case (chanPick)
         2'h2: pllReg = cur.pll3;
         2'h1: pllReg = cur.pll2;
         // channel code 3 also runs channel one
         default: pllReg = cur.pll1;
      endcase
   end

   // decoded outputs, registered
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         // outputs zero while in reset
         setting <= '0;
         activeMode <= 2'h0;
         activeSetB <= 1'b0;
      end else begin
         // mode and set copy for readback
         activeMode <= modeSel[1:0];
         activeSetB <= modeSel[2];
         // all-zero setting means 16384 periods
         if ({cur.onHigh[`ON_HIGH_MSB:0], cur.onLow} == 14'h0000) begin
            setting.onTimePeriods <= 15'h4000;
         end else begin
            // otherwise the plain fourteen-bit setting
            setting.onTimePeriods <= {1'b0, cur.onHigh[`ON_HIGH_MSB:0], cur.onLow};
         end
         // modulation per mode
         unique case (cur.mod[`MOD_TYPE_MSB:0])
            2'h0: setting.modKind <= MOD_ASK;
            2'h1: setting.modKind <= MOD_FSK;
            2'h2: setting.modKind <= (mode == MODE_POLL) ? MOD_FSK : MOD_ASK;
            default: setting.modKind <= (mode == MODE_POLL) ? MOD_ASK : MOD_FSK;
         endcase
         // channel count passed raw
         setting.chanCount <= cur.mod[`MOD_CHAN_MSB:`MOD_CHAN_LSB];
         // band always from the channel one register
         setting.bandSelect <= cur.pll1[`BAND_MSB:`BAND_LSB];
         unique case (cur.pll1[`BAND_MSB:`BAND_LSB])
            2'h0: setting.prescalerA <= 2'h3;
            2'h1: setting.prescalerA <= 2'h2;
            2'h2: setting.prescalerA <= 2'h1;
            default: setting.prescalerA <= 2'h0; // undefined band code
         endcase
         // divider R, code zero is eight
         if (pllReg[`DIV_R_MSB:`DIV_R_LSB] == 3'h0) begin
            setting.chanDiv.divR <= 4'h8;
         end else begin
            // codes one to seven stand for themselves
            setting.chanDiv.divR <= {1'b0, pllReg[`DIV_R_MSB:`DIV_R_LSB]};
         end
         // divider S: plus one, zero, minus one, zero
         unique case (pllReg[`DIV_S_MSB:0])
            2'h0: setting.chanDiv.divS <= 2'sh1;
            2'h2: setting.chanDiv.divS <= -2'sh1;
            default: setting.chanDiv.divS <= 2'sh0;
         endcase
         // wake criterion code passes straight through
         setting.wakeCriterion <= wake_crit_t'(cur.wake[`WAKE_MSB:0]);
         // chip count unused in sync wake mode
         if (cur.wake[`WAKE_MSB:0] == 2'h3) begin
            setting.wakeChipCount <= 7'h00;
         end else begin
            // otherwise the seven-bit count passes
            setting.wakeChipCount <= cur.chipCnt[`CHIP_CNT_MSB:0];
         end
         // pattern counted in chips, high byte on top
         setting.wakePattern <= {cur.patHigh, cur.patLow};
      end
   end
endmodule

// one configuration set: index decode and byte-wide storage
module conf_set_store
   import dual_rx_config_pkg::*;
#(
   parameter logic [6:0] FIRST_IDX = `IDX_A_ON_LOW
) (
   input wire logic clk,
   input wire logic rst_n,
   // both write halves present, no response pending
   input wire logic wrEn,
   // word index of the pending write
   input wire logic [6:0] wrIdx,
   // byte to store, lane 0 only
   input wire logic [7:0] wrByte,
   // strobe of byte lane 0
   input wire logic wrLane,
   // index falls inside this set
   output logic hit,
   // stored registers of this set
   output conf_set_t regs
);
   localparam logic [6:0] LAST_IDX = FIRST_IDX + 7'h09; // chip count is the tenth register
   localparam logic [3:0] TOP_SLOT = 4'h9; // lane of the highest struct byte

   logic [6:0] offs; // index relative to the first register
   logic [3:0] slot; // register position inside the set
   logic [3:0] lane; // byte lane inside the packed struct

   // position decode; out-of-range indices never store
   always_comb begin
      offs = wrIdx - FIRST_IDX;
      hit = (wrIdx >= FIRST_IDX) && (wrIdx <= LAST_IDX);
      slot = offs[3:0];
      // first register sits in the top byte of the struct
      lane = TOP_SLOT - slot;
   end

   // storage, each register back to its own reset value
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         regs <= {`RST_ON_LOW, `RST_ON_HIGH, `RST_MOD, `RST_PLL1, `RST_PLL2,
                  `RST_PLL3, `RST_WAKE, `RST_PAT, `RST_PAT, `RST_CHIP_CNT};
      end else if (wrEn && hit && wrLane) begin
         // other set and other registers keep their bytes
         regs[lane * 8 +: 8] <= wrByte;
      end
   end
endmodule

// [sim/dual_rx_config_chk.sv]
// port checker of the dual configuration bank
module dual_rx_config_chk
   import dual_rx_config_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire rx_setting_t setting
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   logic [1:0] up; // cycles since reset release, saturating
   // outputs settle one edge after release
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         up <= 2'h0;
      end else if (up != 2'h3) begin
         up <= up + 2'h1;
      end
   end
   property p_on_range;
      up == 2'h3 |-> setting.onTimePeriods inside {[15'h1:15'h4000]};
   endproperty
   a_on_range: assert property (p_on_range) else $error("on-time out of range");
   property p_band;
      up == 2'h3 && setting.bandSelect != 2'h3 |-> setting.prescalerA == 2'h3 - setting.bandSelect;
   endproperty
   a_band: assert property (p_band) else $error("prescaler wrong for band");
   property p_div_r;
      up == 2'h3 |-> setting.chanDiv.divR inside {[4'h1:4'h8]};
   endproperty
   a_div_r: assert property (p_div_r) else $error("divider R out of range");
   property p_div_s;
      up == 2'h3 |-> setting.chanDiv.divS != 2'h2;
   endproperty
   a_div_s: assert property (p_div_s) else $error("divider S illegal");
   property p_sync;
      setting.wakeCriterion == WAKE_SYNC |-> setting.wakeChipCount == 7'h0;
   endproperty
   a_sync: assert property (p_sync) else $error("chip count used in sync wake");
   property p_rresp;
      s_axi_rvalid |-> s_axi_rresp == 2'h0;
   endproperty
   a_rresp: assert property (p_rresp) else $error("read response not okay");
   property p_bhold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_bhold: assert property (p_bhold) else $error("write response dropped");
   property p_bans;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
   endproperty
   a_bans: assert property (p_bans) else $error("write response late");
   property p_quiet;
      (up == 2'h3 && !s_axi_bvalid) [*3] |-> $stable(setting);
   endproperty
   a_quiet: assert property (p_quiet) else $error("setting moved without write");
   c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
   c_sync: cover property (setting.wakeCriterion == WAKE_SYNC);
   c_max_on: cover property (setting.onTimePeriods == 15'h4000);
endmodule
bind dual_rx_config_bank dual_rx_config_chk u_chk (.clk(clk), .rst_n(rst_n),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_rresp(s_axi_rresp),
   .s_axi_rvalid(s_axi_rvalid), .setting(setting));

// [sim/dual_rx_config_bank_bench.sv]
// self-checking bench of the dual configuration bank
`include "dual_rx_config_params.svh"
module dual_rx_config_bank_bench import dual_rx_config_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst_n, awV, wV, bRdy, arV, rRdy, awR, wR, bV, arR, rV, setB;
   logic [8:0] awA, arA;
   logic [31:0] wD, rD, rdD;
   logic [1:0] bRsp, rRsp, resp, aMode;
   rx_setting_t st; // decoded outputs
   int error_cnt, n_checks, cyc;
   logic [1:0] sTab [4] = '{2'h1, 2'h0, 2'h3, 2'h0}; // S codes as signed
   dual_rx_config_bank u_dut (.clk(clk), .rst_n(rst_n), .s_axi_awaddr(awA),
      .s_axi_awprot(3'h0), .s_axi_awvalid(awV), .s_axi_awready(awR), .s_axi_wdata(wD),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wV), .s_axi_wready(wR), .s_axi_bresp(bRsp),
      .s_axi_bvalid(bV), .s_axi_bready(bRdy), .s_axi_araddr(arA), .s_axi_arprot(3'h0),
      .s_axi_arvalid(arV), .s_axi_arready(arR), .s_axi_rdata(rD), .s_axi_rresp(rRsp),
      .s_axi_rvalid(rV), .s_axi_rready(rRdy), .setting(st), .activeMode(aMode),
      .activeSetB(setB));
   // free-running clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   // one write by register index, waits for the response
   task automatic wr(input logic [6:0] idx, input logic [7:0] d);
      bit ah, dh;
      ah = 0;
      dh = 0;
      awA <= {idx, 2'h0};
      wD <= {24'h0, d};
      awV <= 1'b1;
      wV <= 1'b1;
      bRdy <= 1'b1;
      while (!(ah && dh)) begin
         @(posedge clk);
         if (awV && awR) ah = 1;
         if (wV && wR) dh = 1;
         awV <= !ah;
         wV <= !dh;
      end
      do @(posedge clk); while (!bV);
      resp = bRsp;
      bRdy <= 1'b0;
      repeat (2) @(posedge clk);
   endtask
   task automatic rd(input logic [6:0] idx);
      arA <= {idx, 2'h0};
      arV <= 1'b1;
      rRdy <= 1'b1;
      do @(posedge clk); while (!arR);
      arV <= 1'b0;
      do @(posedge clk); while (!rV);
      rdD = rD;
      resp = rRsp;
      rRdy <= 1'b0;
      @(posedge clk);
   endtask
   task automatic md(input int m, input logic b);
      wr(`IDX_MODE_SEL, {5'h0, b, 2'(m)});
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // hang guard
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         error_cnt++;
         tally_and_finish();
      end
   end
   initial begin
      {rst_n, awV, wV, bRdy, arV, rRdy, awA, arA, wD} = '0;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      chk(st.onTimePeriods, 32'h1);
      chk({st.bandSelect, st.prescalerA, st.chanDiv}, 32'h188);
      chk({st.modKind, st.chanCount}, 32'h1);
      $display("reset done");
      wr(`IDX_A_ON_HIGH, 8'h00);
      wr(`IDX_A_ON_LOW, 8'h00);
      chk(st.onTimePeriods, 32'h4000);
      wr(`IDX_A_ON_HIGH, 8'hFF);
      wr(`IDX_A_ON_LOW, 8'hFF);
      chk(st.onTimePeriods, 32'h3FFF);
      $display("on-time done");
      for (int i = 0; i < 4; i++) begin
         for (int j = 0; j < 4; j++) begin
            wr(`IDX_A_MOD, 8'(4 + j));
            md(i, 1'b0);
            chk(st.modKind, (j & 1) ^ ((j >> 1) & int'(i == 1)));
         end
      end
      $display("modulation done");
      md(1, 1'b0);
      wr(`IDX_A_PLL2, 8'h0E);
      wr(`IDX_A_PLL3, 8'h1C);
      chk({st.chanCount, st.chanDiv}, 32'h4F);
      wr(`IDX_A_MOD, 8'h08);
      chk({st.chanCount, st.chanDiv}, 32'h9D);
      md(0, 1'b0);
      chk(st.chanDiv, 32'h08);
      for (int i = 0; i < 8; i++) begin
         wr(`IDX_A_PLL1, 8'(32'h20 | (i << 2) | (i & 3)));
         chk(st.chanDiv, ((i == 0 ? 8 : i) << 2) | sTab[i & 3]);
      end
      for (int i = 0; i < 4; i++) begin
         wr(`IDX_A_PLL1, 8'(i << 5));
         chk({st.bandSelect, st.prescalerA}, (i << 2) | (3 - i));
      end
      $display("pll done");
      wr(`IDX_A_CHIP_CNT, 8'h7F);
      for (int i = 0; i < 4; i++) begin
         wr(`IDX_A_WAKE, 8'(i));
         chk({st.wakeCriterion, st.wakeChipCount}, (i << 7) | (i == 3 ? 0 : 'h7F));
      end
      wr(`IDX_A_PAT_LOW, 8'hA5);
      wr(`IDX_A_PAT_HIGH, 8'h3C);
      chk(st.wakePattern, 32'h3CA5);
      $display("wake done");
      md(0, 1'b1);
      chk({setB, st.onTimePeriods}, 32'h8001);
      wr(`IDX_B_PAT_LOW, 8'h5A);
      wr(`IDX_A_PAT_LOW, 8'h11);
      chk(st.wakePattern, 32'h005A);
      md(0, 1'b0);
      chk(st.wakePattern, 32'h3C11);
      $display("set B done");
      rd(`IDX_A_MOD);
      chk(rdD, 32'h0);
      chk(resp, 32'h0);
      wr(7'h7F, 8'h01);
      chk(resp, 32'h2);
      md(2, 1'b1);
      rd(`IDX_MODE_SEL);
      chk({aMode, rdD[2:0]}, 32'h16);
      $display("bus done");
      tally_and_finish();
   end
endmodule
